// file: hw/pmi_pkg.sv
package pmi_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] REG_SUPPLY_GOOD = 8'h02;
   localparam logic [7:0] REG_IRQ_MASK_A = 8'h03;
   localparam logic [7:0] REG_IRQ_MASK_B = 8'h04;
   localparam logic [7:0] REG_IRQ_LATCH_A = 8'h05;
   localparam logic [7:0] REG_IRQ_LATCH_B = 8'h06;
   localparam logic [7:0] REG_FAULT_RESTART_MASK = 8'h07;
   localparam logic [7:0] REG_SW_RESTART = 8'h08;

   // ------------------------------------------------------------
   // field positions of the second mask and latch pair
   // ------------------------------------------------------------
   localparam int BIT_THERMAL = 0;
   localparam int BIT_GPIO_ONE = 1;
   localparam int BIT_GPIO_TWO = 2;
   localparam int BIT_CHARGER_GROUP = 3;
   localparam int BIT_POWER_GROUP = 4;

   // ------------------------------------------------------------
   // values after reset
   // ------------------------------------------------------------
   localparam logic [7:0] IRQ_MASK_RST = 8'h00;
   localparam logic [7:0] FAULT_MASK_RST = 8'hFF;
   localparam logic [7:0] LATCH_RST = 8'h00;

   // ------------------------------------------------------------
   // serial engine
   // ------------------------------------------------------------
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   typedef enum logic [2:0] {
      PMI_WAIT = 3'b000,
      PMI_DEV_ADDR = 3'b001,
      PMI_REG_ADDR = 3'b011,
      PMI_WR_DATA = 3'b010,
      PMI_RD_DATA = 3'b110
   } pmi_phase_e;

endpackage

// file: hw/pmi_evt_if.sv
`timescale 1ns/1ps

interface pmi_evt_if;
   logic [7:0] evt;
   logic [7:0] mask;
   logic clr;
   logic [7:0] latch;
   logic pending;

   modport ctrl (output evt, output mask, output clr, input latch, input pending);
   modport store (input evt, input mask, input clr, output latch, output pending);
endinterface

// file: hw/pmi_irq_latch.sv
`timescale 1ns/1ps

module pmi_irq_latch (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // event group
   pmi_evt_if.store grp
);

   typedef struct packed {
      logic [7:0] latch;
   } pmi_latch_s;

   pmi_latch_s s;
   pmi_latch_s next_s;

   // ------------------------------------------------------------
   // capture
   // ------------------------------------------------------------
   // a new event in the clearing cycle survives the clear
   always_comb begin
      next_s = s;
      next_s.latch = (grp.clr ? pmi_pkg::LATCH_RST : s.latch) | (grp.evt & ~grp.mask);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s.latch <= pmi_pkg::LATCH_RST;
      end else begin
         s <= next_s;
      end
   end

   assign grp.latch = s.latch;
   assign grp.pending = |s.latch;

endmodule

// file: hw/pmi_irq_top.sv
`timescale 1ns/1ps
// Overview of operation
// - interrupt pin is open drain: only pulled low, never driven high
// - thermal fault and both gpio requests each have their own mask bit
// - charger transitions and power transitions are masked as two groups
// - power event on any change of ac, usb, overvoltage or source select
// - the two mask registers live at addresses 3 and 4
// - unmasked requests latch at addresses 5 and 6 until read
// - address 7 picks which supply faults force sleep or restart
// - a write to address 8 starts a software restart
// - address 2 reports live good status of every supply
// - interrupts react to a change of a monitored input, not its level
// - an unmasked supply fault after power-up is done requests a change of operating mode

module pmi_irq_top #(
   // serial slave address, value is arbitrary
   parameter logic [6:0] DEV_ADDR = 7'h2A
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // serial host pins
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // interrupt pin
   output logic intOut,
   output logic intOe,
   // supply monitor: bucks one to three, then adjustable regulators one to five
   input wire logic [7:0] supplyGood,
   input wire logic powerUpDone,
   // system status
   input wire logic thermalFault,
   input wire logic gpioOneReq,
   input wire logic gpioTwoReq,
   // charger status
   input wire logic [1:0] chargePhase,
   input wire logic dynamicPowerLimit,
   input wire logic chargeSuspend,
   input wire logic thermalFoldback,
   // input power status
   input wire logic acPresent,
   input wire logic usbPresent,
   input wire logic inputOvp,
   input wire logic sysFromUsb,
   // mode change requests
   output logic faultModeChange,
   output logic swRestart
);

   typedef struct packed {
      pmi_pkg::pmi_phase_e phase;
      logic sclPrev;
      logic sdaPrev;
      logic [7:0] shift;
      logic [3:0] bitCnt;
      logic inAck;
      logic rw;
      logic sdaLow;
      logic [7:0] regPtr;
      logic [7:0] maskA;
      logic [7:0] maskB;
      logic [7:0] faultMask;
      logic primed;
      logic [7:0] prevGood;
      logic [2:0] prevSys;
      logic [4:0] prevChg;
      logic [3:0] prevPwr;
      logic swRestart;
      logic faultModeChange;
   } pmi_top_s;

   pmi_top_s s;
   pmi_top_s next_s;
   pmi_evt_if evA ();
   pmi_evt_if evB ();

   pmi_irq_latch u_latch_a (
      .sys_clk(sys_clk),
      .rst(rst),
      .grp(evA.store)
   );
   pmi_irq_latch u_latch_b (
      .sys_clk(sys_clk),
      .rst(rst),
      .grp(evB.store)
   );

   // ------------------------------------------------------------
   // register read mux and address checks
   // ------------------------------------------------------------
   logic [7:0] rdByte;
   logic canRead;
   logic canWrite;
   always_comb begin
      if (s.regPtr == pmi_pkg::REG_SUPPLY_GOOD) begin
         rdByte = supplyGood;
      end else if (s.regPtr == pmi_pkg::REG_IRQ_MASK_A) begin
         rdByte = s.maskA;
      end else if (s.regPtr == pmi_pkg::REG_IRQ_MASK_B) begin
         rdByte = s.maskB;
      end else if (s.regPtr == pmi_pkg::REG_IRQ_LATCH_A) begin
         rdByte = evA.latch;
      end else if (s.regPtr == pmi_pkg::REG_IRQ_LATCH_B) begin
         rdByte = evB.latch;
      end else if (s.regPtr == pmi_pkg::REG_FAULT_RESTART_MASK) begin
         rdByte = s.faultMask;
      end else begin
         rdByte = 8'h00;
      end
   end

   // the restart register reads as zero but is a legal pointer target
   assign canRead = (s.shift >= pmi_pkg::REG_SUPPLY_GOOD) && (s.shift <= pmi_pkg::REG_SW_RESTART);
   assign canWrite = (s.regPtr == pmi_pkg::REG_IRQ_MASK_A) ||
                     (s.regPtr == pmi_pkg::REG_IRQ_MASK_B) ||
                     (s.regPtr == pmi_pkg::REG_FAULT_RESTART_MASK) ||
                     (s.regPtr == pmi_pkg::REG_SW_RESTART);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic sclRise;
   logic sclFall;
   logic busStart;
   logic busStop;
   logic [2:0] sysNow;
   logic [4:0] chgNow;
   logic [3:0] pwrNow;
   logic sensing;
   assign sclRise = scl & ~s.sclPrev;
   assign sclFall = ~scl & s.sclPrev;
   assign busStart = scl & s.sclPrev & s.sdaPrev & ~sdaIn;
   assign busStop = scl & s.sclPrev & ~s.sdaPrev & sdaIn;
   assign sysNow = {gpioTwoReq, gpioOneReq, thermalFault};
   assign chgNow = {chargePhase, dynamicPowerLimit, chargeSuspend, thermalFoldback};
   assign pwrNow = {sysFromUsb, inputOvp, usbPresent, acPresent};
   // first cycle after reset only primes the history, so no false change
   assign sensing = s.primed & powerUpDone;

   always_comb begin
      next_s = s;
      next_s.sclPrev = scl;
      next_s.sdaPrev = sdaIn;
      next_s.swRestart = 1'b0;
      evA.clr = 1'b0;
      evB.clr = 1'b0;
      // change detection
      next_s.primed = 1'b1;
      next_s.prevGood = supplyGood;
      next_s.prevSys = sysNow;
      next_s.prevChg = chgNow;
      next_s.prevPwr = pwrNow;
      evA.evt = (supplyGood ^ s.prevGood) & {8{sensing}};
      evA.mask = s.maskA;
      evB.evt = 8'h00;
      evB.evt[pmi_pkg::BIT_THERMAL] = (sysNow[0] ^ s.prevSys[0]) & s.primed;
      evB.evt[pmi_pkg::BIT_GPIO_ONE] = (sysNow[1] ^ s.prevSys[1]) & s.primed;
      evB.evt[pmi_pkg::BIT_GPIO_TWO] = (sysNow[2] ^ s.prevSys[2]) & s.primed;
      evB.evt[pmi_pkg::BIT_CHARGER_GROUP] = (|(chgNow ^ s.prevChg)) & s.primed;
      evB.evt[pmi_pkg::BIT_POWER_GROUP] = (|(pwrNow ^ s.prevPwr)) & s.primed;
      evB.mask = s.maskB;
      // a supply losing its good status is a fault
      next_s.faultModeChange = (|(s.prevGood & ~supplyGood & ~s.faultMask)) & sensing;
      // serial engine: start and stop win over everything else
      if (busStart) begin
         next_s.phase = pmi_pkg::PMI_DEV_ADDR;
         next_s.bitCnt = 4'h0;
         next_s.inAck = 1'b0;
         next_s.sdaLow = 1'b0;
      end else if (busStop) begin
         next_s.phase = pmi_pkg::PMI_WAIT;
         next_s.bitCnt = 4'h0;
         next_s.inAck = 1'b0;
         next_s.sdaLow = 1'b0;
      end else if (s.phase != pmi_pkg::PMI_WAIT) begin
         if (sclRise) begin
            if (s.phase == pmi_pkg::PMI_RD_DATA) begin
               next_s.bitCnt = 4'(s.bitCnt + 4'h1);
            end else if (!s.inAck) begin
               next_s.shift = {s.shift[6:0], sdaIn};
               next_s.bitCnt = 4'(s.bitCnt + 4'h1);
            end
         end else if (sclFall) begin
            if (s.inAck) begin
               // end of our acknowledge clock: act on the byte
               next_s.inAck = 1'b0;
               next_s.sdaLow = 1'b0;
               case (s.phase)
                  pmi_pkg::PMI_DEV_ADDR: begin
                     if (s.rw) begin
                        next_s.phase = pmi_pkg::PMI_RD_DATA;
                        next_s.shift = rdByte;
                        next_s.sdaLow = ~rdByte[7];
                        next_s.bitCnt = 4'h0;
                        evA.clr = (s.regPtr == pmi_pkg::REG_IRQ_LATCH_A);
                        evB.clr = (s.regPtr == pmi_pkg::REG_IRQ_LATCH_B);
                     end else begin
                        next_s.phase = pmi_pkg::PMI_REG_ADDR;
                     end
                  end
                  pmi_pkg::PMI_REG_ADDR: begin
                     next_s.phase = pmi_pkg::PMI_WR_DATA;
                  end
                  pmi_pkg::PMI_WR_DATA: begin
                     next_s.phase = pmi_pkg::PMI_WAIT;
                     if (s.regPtr == pmi_pkg::REG_IRQ_MASK_A) begin
                        next_s.maskA = s.shift;
                     end else if (s.regPtr == pmi_pkg::REG_IRQ_MASK_B) begin
                        next_s.maskB = s.shift;
                     end else if (s.regPtr == pmi_pkg::REG_FAULT_RESTART_MASK) begin
                        next_s.faultMask = s.shift;
                     end else begin
                        next_s.swRestart = 1'b1;
                     end
                  end
                  default: begin
                     next_s.phase = pmi_pkg::PMI_WAIT;
                  end
               endcase
            end else if (s.phase == pmi_pkg::PMI_RD_DATA) begin
               // single byte reads only; host acknowledge is ignored
               if (s.bitCnt == pmi_pkg::BITS_PER_BYTE) begin
                  next_s.sdaLow = 1'b0;
                  next_s.phase = pmi_pkg::PMI_WAIT;
               end else if (s.bitCnt != 4'h0) begin
                  next_s.shift = {s.shift[6:0], 1'b0};
                  next_s.sdaLow = ~s.shift[6];
               end
            end else if (s.bitCnt == pmi_pkg::BITS_PER_BYTE) begin
               // acknowledge slot: pull low to accept, else go idle
               next_s.bitCnt = 4'h0;
               next_s.phase = pmi_pkg::PMI_WAIT;
               case (s.phase)
                  pmi_pkg::PMI_DEV_ADDR: begin
                     if (s.shift[7:1] == DEV_ADDR) begin
                        next_s.phase = s.phase;
                        next_s.rw = s.shift[0];
                        next_s.inAck = 1'b1;
                        next_s.sdaLow = 1'b1;
                     end
                  end
                  pmi_pkg::PMI_REG_ADDR: begin
                     if (canRead) begin
                        next_s.phase = s.phase;
                        next_s.regPtr = s.shift;
                        next_s.inAck = 1'b1;
                        next_s.sdaLow = 1'b1;
                     end
                  end
                  pmi_pkg::PMI_WR_DATA: begin
                     if (canWrite) begin
                        next_s.phase = s.phase;
                        next_s.inAck = 1'b1;
                        next_s.sdaLow = 1'b1;
                     end
                  end
                  default: begin
                     next_s.phase = pmi_pkg::PMI_WAIT;
                  end
               endcase
            end
         end
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s <= '0;
         s.phase <= pmi_pkg::PMI_WAIT;
         s.sclPrev <= 1'b1;
         s.sdaPrev <= 1'b1;
         s.maskA <= pmi_pkg::IRQ_MASK_RST;
         s.maskB <= pmi_pkg::IRQ_MASK_RST;
         s.faultMask <= pmi_pkg::FAULT_MASK_RST;
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   // both open-drain pins only ever pull low
   assign sdaOut = 1'b0;
   assign sdaOe = s.sdaLow;
   assign intOut = 1'b0;
   assign intOe = evA.pending | evB.pending;
   assign faultModeChange = s.faultModeChange;
   assign swRestart = s.swRestart;

endmodule

// file: test/pmi_irq_chk.sv
`timescale 1ns/1ps

module pmi_irq_chk (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // pins
   input wire logic scl,
   input wire logic intOut,
   input wire logic intOe,
   // monitored inputs
   input wire logic [7:0] supplyGood,
   input wire logic powerUpDone,
   input wire logic thermalFault,
   input wire logic gpioOneReq,
   input wire logic gpioTwoReq,
   input wire logic [1:0] chargePhase,
   input wire logic dynamicPowerLimit,
   input wire logic chargeSuspend,
   input wire logic thermalFoldback,
   input wire logic acPresent,
   input wire logic usbPresent,
   input wire logic inputOvp,
   input wire logic sysFromUsb,
   // mode requests
   input wire logic faultModeChange,
   input wire logic swRestart
);
   logic [11:0] oth;
   logic [19:0] mon;

   assign oth = {thermalFault, gpioOneReq, gpioTwoReq, chargePhase, dynamicPowerLimit,
      chargeSuspend, thermalFoldback, acPresent, usbPresent, inputOvp, sysFromUsb};
   assign mon = {supplyGood, oth};

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // ------------------------------------------------------------
   // interrupt pin
   // ------------------------------------------------------------
   chk_int_drain: assert property (intOut == 1'b0)
      else $error("int pin driven high");
   chk_int_cause: assert property ($rose(intOe) |-> $past(mon) != $past(mon, 2))
      else $error("int rose without input change");
   chk_int_quiet: assert property (!intOe && $stable(mon) |=> !intOe)
      else $error("int rose on steady inputs");
   chk_blank_pup: assert property (!intOe && !powerUpDone && $stable(oth) |=> !intOe)
      else $error("supply change not blanked");
   chk_int_hold: assert property (intOe && scl |=> intOe)
      else $error("int released outside a read");

   // ------------------------------------------------------------
   // mode requests
   // ------------------------------------------------------------
   chk_fault_cause: assert property (faultModeChange |-> $past(powerUpDone) &&
      ($past(supplyGood, 2) & ~$past(supplyGood)) != 8'h00)
      else $error("mode change without supply loss");
   chk_restart_one: assert property (swRestart |=> !swRestart)
      else $error("restart pulse too long");
   chk_restart_fall: assert property (swRestart |-> !$past(scl))
      else $error("restart not after ack fall");

   cover property (faultModeChange);
   cover property (swRestart);
   cover property ($fell(intOe));
endmodule

bind pmi_irq_top pmi_irq_chk u_pmi_irq_chk (.sys_clk, .rst, .scl, .intOut, .intOe,
   .supplyGood, .powerUpDone, .thermalFault, .gpioOneReq, .gpioTwoReq, .chargePhase,
   .dynamicPowerLimit, .chargeSuspend, .thermalFoldback, .acPresent, .usbPresent,
   .inputOvp, .sysFromUsb, .faultModeChange, .swRestart);

// file: test/pmi_host_model.sv
`timescale 1ns/1ps

module pmi_host_model #(
   // slave address, value is arbitrary
   parameter logic [6:0] DEV = 7'h2A
) (
   // clock
   input wire logic sys_clk,
   // serial wire
   input wire logic sdaLine,
   output logic scl,
   output logic sdaDrv
);
   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end

   task automatic ph(input logic c, input logic d);
      @(posedge sys_clk);
      scl <= c;
      sdaDrv <= d;
   endtask

   // sample late in the high phase so a slow ack still lands
   task automatic bitx(input logic b, output logic r);
      ph(1'b0, sdaDrv);
      ph(1'b0, b);
      ph(1'b1, b);
      repeat (2) @(posedge sys_clk);
      r = sdaLine;
   endtask

   task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
      bitx(1'b1, a);
      ack = ~a;
   endtask

   // two low cycles let the slave drop its ack before scl rises
   task automatic start;
      repeat (2) ph(1'b0, 1'b1);
      ph(1'b1, 1'b1);
      ph(1'b1, 1'b0);
   endtask

   task automatic stop;
      repeat (2) ph(1'b0, 1'b0);
      ph(1'b1, 1'b0);
      repeat (2) ph(1'b1, 1'b1);
   endtask

   task automatic wr(input logic [7:0] ra, input logic [7:0] d, output logic [2:0] ak);
      logic [7:0] q;
      start;
      xfer({DEV, 1'b0}, q, ak[2]);
      xfer(ra, q, ak[1]);
      xfer(d, q, ak[0]);
      stop;
   endtask

   task automatic rd(input logic [7:0] ra, output logic [7:0] q, output logic [2:0] ak);
      logic n;
      start;
      xfer({DEV, 1'b0}, q, ak[2]);
      xfer(ra, q, ak[1]);
      start;
      xfer({DEV, 1'b1}, q, ak[0]);
      xfer(8'hFF, q, n);
      stop;
   endtask

   // one address byte; a read then takes a byte from the stored pointer
   task automatic rdCur(input logic [7:0] a, output logic [7:0] q, output logic ak);
      logic n;
      start;
      xfer(a, q, ak);
      if (a[0] && ak) xfer(8'hFF, q, n);
      stop;
   endtask
endmodule

// file: test/test_pmi_irq_top.sv
`timescale 1ns/1ps

module test_pmi_irq_top;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic scl, sdaDrv, sdaOut, sdaOe, intOut, intOe, faultModeChange, swRestart;
   logic [7:0] supplyGood = 8'hFF;
   logic powerUpDone = 1'b0;
   logic [11:0] ev = 12'h000;
   logic [7:0] q;
   logic [2:0] ak;
   int fails = 0;
   int samplesChecked = 0;
   int fmcCount = 0;
   int swrCount = 0;
   // open drain: the line only follows the design's level while it drives
   wire sdaLine = sdaDrv & (~sdaOe | sdaOut);

   always #5 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      if (faultModeChange === 1'b1) fmcCount++;
      if (swRestart === 1'b1) swrCount++;
   end

   pmi_irq_top u_pmi_irq_top (.sys_clk, .rst, .scl, .sdaIn(sdaLine), .sdaOut, .sdaOe,
      .intOut, .intOe, .supplyGood, .powerUpDone, .thermalFault(ev[0]),
      .gpioOneReq(ev[1]), .gpioTwoReq(ev[2]), .chargePhase(ev[4:3]),
      .dynamicPowerLimit(ev[5]), .chargeSuspend(ev[6]), .thermalFoldback(ev[7]),
      .acPresent(ev[8]), .usbPresent(ev[9]), .inputOvp(ev[10]), .sysFromUsb(ev[11]),
      .faultModeChange, .swRestart);

   pmi_host_model #(.DEV(7'h2A)) u_pmi_host_model (.sys_clk, .sdaLine, .scl, .sdaDrv);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      samplesChecked++;
      if (got !== want) begin
         fails++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, want);
      end
   endtask

   task automatic rdChk(input logic [7:0] ra, input logic [7:0] want);
      u_pmi_host_model.rd(ra, q, ak);
      chk({5'h00, ak}, 8'h07);
      chk(q, want);
   endtask

   task automatic wrChk(input logic [7:0] ra, input logic [7:0] d, input logic [2:0] wAk);
      u_pmi_host_model.wr(ra, d, ak);
      chk({5'h00, ak}, {5'h00, wAk});
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task report_and_stop;
      $display("checked %0d mismatches %0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      logic [7:0] want;
      idle(12);
      rst <= 1'b0;
      idle(3);
      rdChk(8'h02, 8'hFF);
      rdChk(8'h03, 8'h00);
      rdChk(8'h04, 8'h00);
      rdChk(8'h05, 8'h00);
      rdChk(8'h06, 8'h00);
      rdChk(8'h07, 8'hFF);
      wrChk(8'h09, 8'h00, 3'b100);
      // a refused pointer keeps the old one, so a bare read still sees address 7
      u_pmi_host_model.rdCur({7'h2A, 1'b1}, q, ak[0]);
      chk({7'h00, ak[0]}, 8'h01);
      chk(q, 8'hFF);
      u_pmi_host_model.rdCur({7'h2B, 1'b1}, q, ak[0]);
      chk({7'h00, ak[0]}, 8'h00);
      wrChk(8'h02, 8'h55, 3'b110);
      wrChk(8'h05, 8'h55, 3'b110);
      // supply loss while powering up: no event, no mode change
      supplyGood <= 8'hF0;
      idle(4);
      chk({7'h00, intOe}, 8'h00);
      rdChk(8'h05, 8'h00);
      powerUpDone <= 1'b1;
      rdChk(8'h02, 8'hF0);
      // every status source, rising then falling
      for (int k = 0; k < 24; k++) begin
         want = (k % 12) < 3 ? 8'h01 << (k % 12) : ((k % 12) < 8 ? 8'h08 : 8'h10);
         ev[k % 12] <= ~ev[k % 12];
         idle(3);
         chk({7'h00, intOe}, 8'h01);
         rdChk(8'h06, want);
         chk({7'h00, intOe}, 8'h00);
      end
      for (int m = 0; m < 2; m++) begin
         want = m == 0 ? 8'h09 : 8'h16;
         wrChk(8'h04, want, 3'b111);
         rdChk(8'h04, want);
         ev <= ~ev;
         idle(3);
         rdChk(8'h06, ~want & 8'h1F);
      end
      wrChk(8'h04, 8'h00, 3'b111);
      // supply events and restart mask
      wrChk(8'h03, 8'hFC, 3'b111);
      wrChk(8'h07, 8'hFE, 3'b111);
      supplyGood <= 8'hF3;
      idle(3);
      rdChk(8'h05, 8'h03);
      supplyGood <= 8'hF0;
      idle(3);
      chk(8'(fmcCount), 8'h01);
      rdChk(8'h05, 8'h03);
      supplyGood <= 8'hF4;
      idle(3);
      chk({7'h00, intOe}, 8'h00);
      rdChk(8'h05, 8'h00);
      // software restart
      wrChk(8'h08, 8'h01, 3'b111);
      idle(2);
      chk(8'(swrCount), 8'h01);
      report_and_stop;
   end

   initial begin
      repeat (40000) @(posedge sys_clk);
      fails++;
      report_and_stop;
   end
endmodule
